/* File: tws_pkg.sv */
// Purpose: Shared constants and types for the two-wire slave and its master
// Assumes: 40 MHz ref_clk on both ends, open-drain lines resolved in tws_if
// Notes: Cycle counts below assume the 40 MHz ref_clk
// What this block does
// - Alert joins alert protocol only in interrupt mode
// - Active alert acks alert address, returns own address
// - Returned address LSB shows high or low limit
// - Arbitrate on address; winner clears alert, loser keeps
// - Ack general call address with write direction
// - General call 04h re-samples address pins only
// - General call 06h resets registers to power-up
// - Hs master code unacked, raises hs_mode output; filters unchanged
// - Master sends Hs code first after start
// - Hs mode holds until stop, then fast mode
// - Line low 54 ms inside frame resets interface
// - After timeout release bus, wait for start
// - Master clocks at 1 kHz or faster
// - Start is data falling while clock high
// - Stop is data rising while clock high
// - Both lines high means bus idle
// - Any number of data bytes per frame
// - Write ended after MSB updates only MSB
// - Receiver holds data low through ninth clock high
// - Master ends read with not-acknowledge
// - Interrupt alert holds until register read or answer
// - General call reset clears alert, selects comparator mode
// - Address is 1001 plus pins, latched at start
package tws_pkg;
	localparam int        CLK_HZ      = 40_000_000;
	localparam int        TO_MS       = 54;
	localparam int        TO_CYC      = TO_MS * (CLK_HZ / 1000);
	localparam int        SCL_KHZ     = 400;
	localparam int        QTR_CYC     = CLK_HZ / (SCL_KHZ * 1000 * 4);
	localparam int        FIFO_DEPTH  = 32;
	localparam int        CMD_W       = 10;
	localparam logic [3:0] ADDR_BASE  = 4'h9;
	localparam logic [6:0] ARA_ADDR   = 7'h0c;
	localparam logic [7:0] GC_WR_BYTE = 8'h00;
	localparam logic [7:0] GC_RELATCH = 8'h04;
	localparam logic [7:0] GC_RESET   = 8'h06;
	localparam logic [4:0] HS_CODE    = 5'h01;
	localparam logic [1:0] PTR_CFG    = 2'h1;
	localparam int        CFG_TM_BIT  = 9;
	localparam logic [7:0] PTR_RST    = 8'h00;
	localparam logic [4:0] SYNC_RST   = 5'h1f;
	localparam logic [3:0] BYTE_BITS  = 4'h8;
	localparam logic [1:0] BE_FULL    = 2'h3;
	localparam logic [1:0] BE_MSB     = 2'h2;
	typedef enum logic [1:0] {TWS_OP_START, TWS_OP_WR, TWS_OP_RD, TWS_OP_STOP} tws_op_e;
endpackage

/* File: tws_if.sv */
// Purpose: Open-drain two-wire bus plus alert line joining master and slave
// Assumes: A driver enabling its pin with output 0 pulls the line low
// Notes: Undriven lines read high, as with pull-ups
interface tws_if;
	logic scl;
	logic sda;
	logic alert_n;
	logic m_scl_o;
	logic m_scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	logic s_sda_o;
	logic s_sda_oe;
	logic s_alert_o;
	logic s_alert_oe;
	assign scl     = ~(m_scl_oe & ~m_scl_o);
	assign sda     = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));
	assign alert_n = ~(s_alert_oe & ~s_alert_o);
	modport master (input scl, sda, alert_n, output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe);
	modport slave  (input scl, sda, output s_sda_o, s_sda_oe, s_alert_o, s_alert_oe);
endinterface

/* File: tws_slave.sv */
// Purpose: Two-wire slave with alert answer, general call, Hs switch, timeout
// Assumes: Master never stretches; no clock stretching by this end
// Notes: Lines pass a three-stage filter, so SCL high/low must last at least 2 cycles
module tws_slave #(
	parameter int TIMEOUT_CYC = tws_pkg::TO_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	tws_if.slave             bus,
	input  wire logic [2:0]  addr_sel,
	input  wire logic [15:0] rd_data,
	input  wire logic        fault_hi,
	input  wire logic        fault_lo,
	output logic [7:0]       reg_ptr,
	output logic             wr_stb,
	output logic [1:0]       wr_be,
	output logic [15:0]      wr_data,
	output logic             rd_stb,
	output logic             gc_rst,
	output logic             hs_mode,
	output logic             alert_interrupt_select,
	output logic             alert_active
);
	localparam int TO_W = $clog2(TIMEOUT_CYC + 1);
	typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_WAIT} tws_st_e;
	typedef enum logic [2:0] {RO_ADDR, RO_PTR, RO_DATA, RO_GCMD, RO_TXREG, RO_TXARA} tws_role_e;

	logic [4:0]  s1_r, s2_r, s3_r, filt_r;
	logic        scl_p_r, sda_p_r;
	tws_st_e     st_r, st_nxt;
	tws_role_e   role_r, role_nxt;
	logic [3:0]  cnt_r, cnt_nxt;
	logic [7:0]  sh_r, sh_nxt, tx_r, tx_nxt, ptr_r, ptr_nxt;
	logic [15:0] word_r, word_nxt, wdata_r, wdata_nxt;
	logic [1:0]  wbe_r, wbe_nxt;
	logic [6:0]  my_addr_r, my_addr_nxt;
	logic        hi_r, hi_nxt, half_r, half_nxt, first_r, first_nxt;
	logic        wstb_r, wstb_nxt, rdstb_r, rdstb_nxt, gcrst_r, gcrst_nxt;
	logic        hs_r, hs_nxt, busy_r, busy_nxt, oe_r, oe_nxt;
	logic        alert_r, alert_nxt, dir_r, dir_nxt, tm_r, tm_nxt;
	logic [TO_W-1:0] to_cnt_r;

	wire scl_f     = filt_r[0];
	wire sda_f     = filt_r[1];
	wire [2:0] pins_f = filt_r[4:2];
	wire scl_rise  = scl_f & ~scl_p_r;
	wire scl_fall  = ~scl_f & scl_p_r;
	wire start_c   = scl_f & scl_p_r & sda_p_r & ~sda_f;
	wire stop_c    = scl_f & scl_p_r & ~sda_p_r & sda_f;
	wire byte_end  = scl_fall & (cnt_r == tws_pkg::BYTE_BITS);
	wire lines_hi  = scl_f & sda_f;
	wire to_hit    = to_cnt_r == TO_W'(TIMEOUT_CYC - 1);
	wire is_own    = sh_r[7:1] == my_addr_r;
	wire is_ara    = (sh_r[7:1] == tws_pkg::ARA_ADDR) & sh_r[0];
	wire is_hs     = first_r & (sh_r[7:3] == tws_pkg::HS_CODE);
	wire part_wr   = (role_r == RO_DATA) & half_r;

	// Filter: a change counts once stages two and three agree
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_r    <= tws_pkg::SYNC_RST;
			s2_r    <= tws_pkg::SYNC_RST;
			s3_r    <= tws_pkg::SYNC_RST;
			filt_r  <= tws_pkg::SYNC_RST;
			scl_p_r <= 1'b1;
			sda_p_r <= 1'b1;
		end
		else
		begin
			s1_r    <= {addr_sel, bus.sda, bus.scl};
			s2_r    <= s1_r;
			s3_r    <= s2_r;
			filt_r  <= (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
			scl_p_r <= scl_f;
			sda_p_r <= sda_f;
		end
	end

	// Low-time watchdog, only counts inside a frame
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			to_cnt_r <= '0;
		else if (!busy_r || lines_hi)
			to_cnt_r <= '0;
		else if (!to_hit)
			to_cnt_r <= to_cnt_r + 1'b1;
	end

	always_comb
	begin
		st_nxt      = st_r;
		role_nxt    = role_r;
		cnt_nxt     = cnt_r;
		sh_nxt      = sh_r;
		tx_nxt      = tx_r;
		ptr_nxt     = ptr_r;
		word_nxt    = word_r;
		wdata_nxt   = wdata_r;
		wbe_nxt     = wbe_r;
		my_addr_nxt = my_addr_r;
		hi_nxt      = hi_r;
		half_nxt    = half_r;
		first_nxt   = first_r;
		hs_nxt      = hs_r;
		busy_nxt    = busy_r;
		oe_nxt      = oe_r;
		alert_nxt   = alert_r;
		dir_nxt     = dir_r;
		tm_nxt      = tm_r;
		wstb_nxt    = 1'b0;
		rdstb_nxt   = 1'b0;
		gcrst_nxt   = 1'b0;
		if (to_hit)
		begin
			st_nxt   = ST_IDLE;
			oe_nxt   = 1'b0;
			busy_nxt = 1'b0;
			half_nxt = 1'b0;
		end
		else if (start_c || stop_c)
		begin
			if (part_wr)
			begin
				wstb_nxt = 1'b1;
				wbe_nxt  = tws_pkg::BE_MSB;
			end
			half_nxt = 1'b0;
			oe_nxt   = 1'b0;
			cnt_nxt  = '0;
			if (start_c)
			begin
				st_nxt      = ST_RX;
				role_nxt    = RO_ADDR;
				first_nxt   = 1'b1;
				busy_nxt    = 1'b1;
				my_addr_nxt = {tws_pkg::ADDR_BASE, pins_f};
			end
			else
			begin
				st_nxt   = ST_IDLE;
				busy_nxt = 1'b0;
				hs_nxt   = 1'b0;
			end
		end
		else
		begin
			case (st_r)
				ST_RX:
				begin
					if (scl_rise && cnt_r != tws_pkg::BYTE_BITS)
					begin
						sh_nxt  = {sh_r[6:0], sda_f};
						cnt_nxt = cnt_r + 1'b1;
					end
					else if (byte_end)
					begin
						cnt_nxt   = '0;
						first_nxt = 1'b0;
						oe_nxt    = 1'b1;
						st_nxt    = ST_ACK;
						case (role_r)
							RO_ADDR:
							begin
								if (is_hs)
								begin
									hs_nxt = 1'b1;
									oe_nxt = 1'b0;
									st_nxt = ST_WAIT;
								end
								else if (is_own && sh_r[0])
								begin
									role_nxt  = RO_TXREG;
									tx_nxt    = rd_data[15:8];
									word_nxt  = rd_data;
									hi_nxt    = 1'b0;
									rdstb_nxt = 1'b1;
									if (tm_r)
										alert_nxt = 1'b0;
								end
								else if (is_own)
									role_nxt = RO_PTR;
								else if (is_ara && tm_r && alert_r)
								begin
									role_nxt = RO_TXARA;
									tx_nxt   = {my_addr_r, dir_r};
								end
								else if (sh_r == tws_pkg::GC_WR_BYTE)
									role_nxt = RO_GCMD;
								else
								begin
									oe_nxt = 1'b0;
									st_nxt = ST_WAIT;
								end
							end
							RO_PTR:
							begin
								ptr_nxt  = sh_r;
								role_nxt = RO_DATA;
							end
							RO_DATA:
							begin
								if (!half_r)
									wdata_nxt[15:8] = sh_r;
								else
								begin
									wdata_nxt[7:0] = sh_r;
									wstb_nxt       = 1'b1;
									wbe_nxt        = tws_pkg::BE_FULL;
								end
								half_nxt = ~half_r;
							end
							RO_GCMD:
							begin
								if (sh_r == tws_pkg::GC_RELATCH)
									my_addr_nxt = {tws_pkg::ADDR_BASE, pins_f};
								if (sh_r == tws_pkg::GC_RESET)
									gcrst_nxt = 1'b1;
							end
							default:
								st_nxt = ST_WAIT;
						endcase
					end
				end
				ST_ACK:
				begin
					if (scl_fall)
					begin
						oe_nxt = 1'b0;
						st_nxt = ST_RX;
						if (role_r == RO_TXREG || role_r == RO_TXARA)
						begin
							st_nxt = ST_TX;
							oe_nxt = ~tx_r[7];
							tx_nxt = {tx_r[6:0], 1'b1};
						end
					end
				end
				ST_TX:
				begin
					if (scl_rise)
					begin
						cnt_nxt = cnt_r + 1'b1;
						if (role_r == RO_TXARA && !oe_r && !sda_f)
							st_nxt = ST_WAIT;
					end
					else if (scl_fall && cnt_r == tws_pkg::BYTE_BITS)
					begin
						oe_nxt = 1'b0;
						st_nxt = ST_MACK;
					end
					else if (scl_fall)
					begin
						oe_nxt = ~tx_r[7];
						tx_nxt = {tx_r[6:0], 1'b1};
					end
				end
				ST_MACK:
				begin
					if (scl_rise)
					begin
						cnt_nxt = '0;
						st_nxt  = ST_WAIT;
						if (role_r == RO_TXARA)
							alert_nxt = 1'b0;
						else if (!sda_f)
						begin
							st_nxt = ST_TX;
							tx_nxt = hi_r ? word_r[15:8] : word_r[7:0];
							hi_nxt = ~hi_r;
						end
					end
				end
				default:
					st_nxt = st_r;
			endcase
		end
		if (wstb_nxt && wbe_nxt[1] && ptr_r[1:0] == tws_pkg::PTR_CFG)
			tm_nxt = wdata_nxt[tws_pkg::CFG_TM_BIT];
		if (gcrst_nxt)
		begin
			alert_nxt = 1'b0;
			tm_nxt    = 1'b0;
			ptr_nxt   = tws_pkg::PTR_RST;
		end
		// Limit events come last so a set beats any clear in the same cycle
		if (fault_hi)
		begin
			alert_nxt = 1'b1;
			dir_nxt   = 1'b1;
		end
		else if (fault_lo)
		begin
			alert_nxt = tm_nxt;
			dir_nxt   = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r      <= ST_IDLE;
			role_r    <= RO_ADDR;
			cnt_r     <= '0;
			sh_r      <= '0;
			tx_r      <= '0;
			ptr_r     <= tws_pkg::PTR_RST;
			word_r    <= '0;
			wdata_r   <= '0;
			wbe_r     <= '0;
			my_addr_r <= {tws_pkg::ADDR_BASE, 3'h0};
			{hi_r, half_r, first_r, wstb_r, rdstb_r, gcrst_r} <= '0;
			{hs_r, busy_r, oe_r, alert_r, dir_r, tm_r} <= '0;
		end
		else
		begin
			st_r      <= st_nxt;
			role_r    <= role_nxt;
			cnt_r     <= cnt_nxt;
			sh_r      <= sh_nxt;
			tx_r      <= tx_nxt;
			ptr_r     <= ptr_nxt;
			word_r    <= word_nxt;
			wdata_r   <= wdata_nxt;
			wbe_r     <= wbe_nxt;
			my_addr_r <= my_addr_nxt;
			{hi_r, half_r, first_r} <= {hi_nxt, half_nxt, first_nxt};
			{wstb_r, rdstb_r, gcrst_r} <= {wstb_nxt, rdstb_nxt, gcrst_nxt};
			{hs_r, busy_r, oe_r} <= {hs_nxt, busy_nxt, oe_nxt};
			{alert_r, dir_r, tm_r} <= {alert_nxt, dir_nxt, tm_nxt};
		end
	end

	assign bus.s_sda_o            = 1'b0;
	assign bus.s_sda_oe           = oe_r;
	assign bus.s_alert_o          = 1'b0;
	assign bus.s_alert_oe         = alert_r;
	assign reg_ptr                = ptr_r;
	assign wr_stb                 = wstb_r;
	assign wr_be                  = wbe_r;
	assign wr_data                = wdata_r;
	assign rd_stb                 = rdstb_r;
	assign gc_rst                 = gcrst_r;
	assign hs_mode                = hs_r;
	assign alert_interrupt_select = tm_r;
	assign alert_active           = alert_r;
endmodule

/* File: tws_master.sv */
// Purpose: Two-wire bus master fed by a command FIFO
// Assumes: Slave does not stretch SCL; commands are well ordered by the user
// Notes: SCL is made here by a quarter-period divider of ref_clk
module tws_fifo #(
	parameter int W = tws_pkg::CMD_W,
	parameter int D = tws_pkg::FIFO_DEPTH
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [D];
	logic [AW-1:0] wp_r, rp_r;
	logic [AW:0]   cnt_r;
	logic          in_ready_r, out_valid_r;
	wire push = in_valid & in_ready_r;
	wire pop  = out_ready & out_valid_r;
	wire [AW:0] cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);

	always_ff @(posedge ref_clk)
	begin
		if (push)
			mem[wp_r] <= in_data;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{wp_r, rp_r, cnt_r} <= '0;
			in_ready_r  <= 1'b1;
			out_valid_r <= 1'b0;
		end
		else
		begin
			wp_r        <= wp_r + AW'(push);
			rp_r        <= rp_r + AW'(pop);
			cnt_r       <= cnt_nxt;
			in_ready_r  <= cnt_nxt != (AW+1)'(D);
			out_valid_r <= cnt_nxt != '0;
		end
	end
	assign in_ready  = in_ready_r;
	assign out_valid = out_valid_r;
	assign out_data  = mem[rp_r];
endmodule

module tws_master #(
	parameter int QTR   = tws_pkg::QTR_CYC,
	parameter int DEPTH = tws_pkg::FIFO_DEPTH
) (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	tws_if.master           bus,
	input  wire logic       cmd_valid,
	output logic            cmd_ready,
	input  wire logic [1:0] cmd_op,
	input  wire logic [7:0] cmd_data,
	output logic            rsp_valid,
	output logic [7:0]      rsp_data,
	output logic            rsp_ack,
	output logic            alert_seen
);
	localparam int QW = $clog2(QTR + 1);
	typedef enum logic [1:0] {HM_IDLE, HM_START, HM_BIT, HM_STOP} tws_hst_e;
	logic [2:0]   s1_r, s2_r, s3_r, filt_r;
	tws_hst_e     st_r;
	logic [QW-1:0] q_cnt_r;
	logic [1:0]   q_r;
	logic [8:0]   sh_r;
	logic [3:0]   bit_r;
	logic [7:0]   rx_r;
	logic         scl_oe_r, sda_oe_r, rsp_v_r, ack_r;
	logic         f_valid;
	logic [9:0]   f_data;
	wire take = (st_r == HM_IDLE) & f_valid;
	wire tick = q_cnt_r == QW'(QTR - 1);
	wire [1:0] f_op = f_data[9:8];
	wire sda_f = filt_r[1];

	tws_fifo #(.W(tws_pkg::CMD_W), .D(DEPTH)) u_fifo (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.in_valid  (cmd_valid),
		.in_ready  (cmd_ready),
		.in_data   ({cmd_op, cmd_data}),
		.out_valid (f_valid),
		.out_ready (take),
		.out_data  (f_data)
	);

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{s1_r, s2_r, s3_r, filt_r} <= '1;
		end
		else
		begin
			s1_r   <= {bus.alert_n, bus.sda, bus.scl};
			s2_r   <= s1_r;
			s3_r   <= s2_r;
			filt_r <= (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r     <= HM_IDLE;
			q_cnt_r  <= '0;
			q_r      <= '0;
			sh_r     <= '1;
			bit_r    <= '0;
			rx_r     <= '0;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
			rsp_v_r  <= 1'b0;
			ack_r    <= 1'b0;
		end
		else
		begin
			rsp_v_r <= 1'b0;
			q_cnt_r <= (take || tick) ? '0 : q_cnt_r + 1'b1;
			if (take)
			begin
				q_r   <= '0;
				bit_r <= '0;
				// First byte after a start may be the Hs code
				sh_r  <= (f_op == tws_pkg::TWS_OP_RD) ? {8'hff, f_data[0]} : {f_data[7:0], 1'b1};
				case (f_op)
					tws_pkg::TWS_OP_START: st_r <= HM_START;
					tws_pkg::TWS_OP_STOP:  st_r <= HM_STOP;
					default:               st_r <= HM_BIT;
				endcase
			end
			else if (tick && st_r != HM_IDLE)
			begin
				q_r <= q_r + 1'b1;
				case (st_r)
					HM_START:
					begin
						case (q_r)
							2'h0: sda_oe_r <= 1'b0;
							2'h1: scl_oe_r <= 1'b0;
							2'h2: sda_oe_r <= 1'b1;
							default:
							begin
								scl_oe_r <= 1'b1;
								st_r     <= HM_BIT;
							end
						endcase
					end
					HM_BIT:
					begin
						case (q_r)
							2'h0: sda_oe_r <= ~sh_r[8];
							2'h1: scl_oe_r <= 1'b0;
							2'h2:
							begin
								if (bit_r == tws_pkg::BYTE_BITS)
									ack_r <= ~sda_f;
								else
									rx_r <= {rx_r[6:0], sda_f};
							end
							default:
							begin
								scl_oe_r <= 1'b1;
								sh_r     <= {sh_r[7:0], 1'b1};
								bit_r    <= bit_r + 1'b1;
								if (bit_r == tws_pkg::BYTE_BITS)
								begin
									st_r    <= HM_IDLE;
									rsp_v_r <= 1'b1;
								end
							end
						endcase
					end
					HM_STOP:
					begin
						case (q_r)
							2'h0: sda_oe_r <= 1'b1;
							2'h1: scl_oe_r <= 1'b0;
							2'h2: sda_oe_r <= 1'b0;
							default: st_r <= HM_IDLE;
						endcase
					end
					default: st_r <= HM_IDLE;
				endcase
			end
		end
	end

	assign bus.m_scl_o  = 1'b0;
	assign bus.m_scl_oe = scl_oe_r;
	assign bus.m_sda_o  = 1'b0;
	assign bus.m_sda_oe = sda_oe_r;
	assign rsp_valid    = rsp_v_r;
	assign rsp_data     = rx_r;
	assign rsp_ack      = ack_r;
	assign alert_seen   = ~filt_r[2];
endmodule

/* File: tws_chk.sv */
// Purpose: Wire-level checks on the link that joins master and slave
// Assumes: Raw resolved lines sampled on ref_clk, filter lag of a few cycles
// Notes: Only the first byte after each start is decoded, as it selects the mode
module tws_chk (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sda,
	input wire logic s_sda_oe,
	input wire logic s_alert_oe
);
	logic       scl_q;
	logic       sda_q;
	logic       frame_r;
	logic       first_r;
	logic [3:0] cnt_r;
	logic [7:0] sh_r;
	wire        start_w = scl & scl_q & sda_q & ~sda;
	wire        stop_w  = scl & scl_q & ~sda_q & sda;
	wire        rise_w  = scl & ~scl_q;
	wire        ack9_w  = rise_w & first_r & (cnt_r == 4'h8);

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			frame_r <= 1'b0;
			first_r <= 1'b0;
			cnt_r <= 4'h0;
			sh_r <= 8'h00;
		end
		else
		begin
			scl_q <= scl;
			sda_q <= sda;
			frame_r <= start_w | (frame_r & ~stop_w);
			first_r <= start_w | (first_r & ~ack9_w);
			cnt_r <= (start_w | (rise_w & cnt_r == 4'h8)) ? 4'h0 : cnt_r + {3'h0, rise_w};
			sh_r <= (rise_w && cnt_r < 4'h8) ? {sh_r[6:0], sda} : sh_r;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// Ack or data low must cover at least half of the high phase
	sequence low_held;
		s_sda_oe [*8];
	endsequence

	a_pull_in_low: assert property ($rose(s_sda_oe) |-> !scl)
		else $error("slave pulled sda while scl high");
	a_release_in_low: assert property ($fell(s_sda_oe) |-> !scl)
		else $error("slave released sda while scl high");
	a_ack_holds: assert property (rise_w && s_sda_oe |=> low_held)
		else $error("slave low drive ended early in high phase");
	a_gcall_ack: assert property (ack9_w && sh_r == tws_pkg::GC_WR_BYTE |-> !sda)
		else $error("general call not acknowledged");
	a_hs_noack: assert property (ack9_w && sh_r[7:3] == tws_pkg::HS_CODE |-> sda)
		else $error("hs master code acknowledged");
	a_ara_quiet: assert property (
		ack9_w && sh_r == {tws_pkg::ARA_ADDR, 1'b1} && !s_alert_oe |-> sda)
		else $error("alert address acknowledged with alert inactive");
	a_idle_free: assert property (!frame_r |-> !s_sda_oe)
		else $error("slave drives sda outside a frame");
	// Start and stop belong to the master, so the slave must never move sda in a high phase
	a_bit_stable: assert property (
		frame_r && scl && scl_q && sda != sda_q |-> $stable(s_sda_oe) && !s_sda_oe)
		else $error("slave moved sda inside a bit high phase");
endmodule

/* File: test_two_wire_slave_alert_gcall_hs.sv */
// Purpose: Self-checking bench of master and slave facing each other
// Assumes: QTR of 8 and a 2000-cycle timeout keep the run short
// Notes: Arbitration loss needs a second alert source and is left to later work
module test_two_wire_slave_alert_gcall_hs;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TO = 2000;
	typedef struct packed {
		logic [1:0] op;
		logic [7:0] d;
		logic       ack;
		logic [7:0] rd;
		logic       hs;
	} tws_row_s;
	localparam tws_row_s ROWS [18] = '{
		'{2'h0, 8'h9a, 1'b1, 8'h00, 1'b0}, '{2'h1, 8'h01, 1'b1, 8'h00, 1'b0},
		'{2'h1, 8'h02, 1'b1, 8'h00, 1'b0}, '{2'h1, 8'h34, 1'b1, 8'h00, 1'b0},
		'{2'h3, 8'h00, 1'b0, 8'h00, 1'b0}, '{2'h0, 8'h9b, 1'b1, 8'h00, 1'b0},
		'{2'h2, 8'h00, 1'b1, 8'hc3, 1'b0}, '{2'h2, 8'h01, 1'b0, 8'h5a, 1'b0},
		'{2'h3, 8'h00, 1'b0, 8'h00, 1'b0}, '{2'h0, 8'h00, 1'b1, 8'h00, 1'b0},
		'{2'h1, 8'h04, 1'b1, 8'h00, 1'b0}, '{2'h3, 8'h00, 1'b0, 8'h00, 1'b0},
		'{2'h0, 8'h09, 1'b0, 8'h00, 1'b1}, '{2'h0, 8'h9a, 1'b1, 8'h00, 1'b1},
		'{2'h1, 8'h01, 1'b1, 8'h00, 1'b1}, '{2'h3, 8'h00, 1'b0, 8'h00, 1'b0},
		'{2'h0, 8'ha0, 1'b0, 8'h00, 1'b0}, '{2'h3, 8'h00, 1'b0, 8'h00, 1'b0}};
	logic        ref_clk;
	logic        rst_n;
	logic        cmd_valid;
	logic        cmd_ready;
	logic [1:0]  cmd_op;
	logic [7:0]  cmd_data;
	logic        rsp_valid;
	logic [7:0]  rsp_data;
	logic        rsp_ack;
	logic        alert_seen;
	logic [2:0]  addr_sel;
	logic [15:0] rd_data;
	logic        fault_hi;
	logic        fault_lo;
	logic [7:0]  reg_ptr;
	logic        wr_stb;
	logic [1:0]  wr_be;
	logic [15:0] wr_data;
	logic        rd_stb;
	logic        gc_rst;
	logic        hs_mode;
	logic        int_sel;
	logic        alert_active;
	logic        saw_full;
	int          err_total;
	int          samples_checked;
	int          ack_cnt;
	int          stb_cnt;
	int          gc_cnt;
	int          rd_cnt;
	int          base_a;
	int          base_s;
	tws_if u_bus ();
	tws_if u_bus_b ();
	tws_master #(.QTR(8)) i_tws_master (.ref_clk(ref_clk), .rst_n(rst_n), .bus(u_bus),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack), .alert_seen(alert_seen));
	tws_slave #(.TIMEOUT_CYC(TO)) i_tws_slave (.ref_clk(ref_clk), .rst_n(rst_n), .bus(u_bus),
		.addr_sel(addr_sel), .rd_data(rd_data), .fault_hi(fault_hi), .fault_lo(fault_lo),
		.reg_ptr(reg_ptr), .wr_stb(wr_stb), .wr_be(wr_be), .wr_data(wr_data), .rd_stb(rd_stb),
		.gc_rst(gc_rst), .hs_mode(hs_mode), .alert_interrupt_select(int_sel),
		.alert_active(alert_active));
	// Second slave faces a bench driver that holds scl low on purpose
	tws_slave #(.TIMEOUT_CYC(TO)) i_tws_slave_b (.ref_clk(ref_clk), .rst_n(rst_n),
		.bus(u_bus_b), .addr_sel(addr_sel), .rd_data(rd_data), .fault_hi(1'b0),
		.fault_lo(1'b0), .reg_ptr(), .wr_stb(), .wr_be(), .wr_data(), .rd_stb(), .gc_rst(),
		.hs_mode(), .alert_interrupt_select(), .alert_active());
	tws_chk i_tws_chk (.ref_clk(ref_clk), .rst_n(rst_n), .scl(u_bus.scl), .sda(u_bus.sda),
		.s_sda_oe(u_bus.s_sda_oe), .s_alert_oe(u_bus.s_alert_oe));

	always #12.5 ref_clk = ~ref_clk;

	always @(posedge ref_clk)
	begin
		if (rsp_valid === 1'b1 && rsp_ack === 1'b1) ack_cnt++;
		if (wr_stb === 1'b1) stb_cnt++;
		if (gc_rst === 1'b1) gc_cnt++;
		if (rd_stb === 1'b1) rd_cnt++;
		if (cmd_ready === 1'b0) saw_full = 1'b1;
	end

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic push(input logic [1:0] op, input logic [7:0] d);
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_data <= d;
		@(posedge ref_clk);
		while (cmd_ready !== 1'b1)
			@(posedge ref_clk);
		cmd_valid <= 1'b0;
	endtask

	// Stop has no answer: wait out its four quarters plus filter lag
	task automatic xfer(input logic [1:0] op, input logic [7:0] d, input logic ack,
		input logic [7:0] rd);
		int n;
		push(op, d);
		n = 0;
		if (op == 2'h3)
			repeat (48) @(posedge ref_clk);
		else
		begin
			while (rsp_valid !== 1'b1 && n < 2000)
			begin
				@(posedge ref_clk);
				n++;
			end
			chk("rsp_seen", {15'h0000, rsp_valid}, 16'h0001);
			chk("rsp_ack", {15'h0000, rsp_ack}, {15'h0000, ack});
			if (op == 2'h2)
				chk("rsp_data", {8'h00, rsp_data}, {8'h00, rd});
		end
	endtask

	task automatic fault(input logic hi);
		fault_hi <= hi;
		fault_lo <= !hi;
		@(posedge ref_clk);
		fault_hi <= 1'b0;
		fault_lo <= 1'b0;
		repeat (8) @(posedge ref_clk);
	endtask

	// Alert address read back with the expected limit direction
	task automatic ara(input logic [7:0] rd);
		xfer(2'h0, 8'h19, 1'b1, 8'h00);
		xfer(2'h2, 8'h01, 1'b0, rd);
		xfer(2'h3, 8'h00, 1'b0, 8'h00);
		chk("alert_active", {15'h0000, alert_active}, 16'h0000);
	endtask

	task automatic bb(input logic b);
		u_bus_b.m_sda_oe <= !b;
		repeat (8) @(posedge ref_clk);
		u_bus_b.m_scl_oe <= 1'b0;
		repeat (16) @(posedge ref_clk);
		u_bus_b.m_scl_oe <= 1'b1;
		repeat (8) @(posedge ref_clk);
	endtask

	initial
	begin
		#(25 * 60000);
		err_total++;
		finish_test();
	end

	initial
	begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = 2'h0;
		cmd_data = 8'h00;
		addr_sel = 3'h5;
		rd_data = 16'hc35a;
		fault_hi = 1'b0;
		fault_lo = 1'b0;
		saw_full = 1'b0;
		u_bus_b.m_scl_o = 1'b0;
		u_bus_b.m_sda_o = 1'b0;
		u_bus_b.m_scl_oe = 1'b0;
		u_bus_b.m_sda_oe = 1'b0;
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge ref_clk);
		chk("reset", {2'h0, reg_ptr, int_sel, hs_mode, alert_active, cmd_ready, u_bus.scl,
			u_bus.sda}, {2'h0, 8'h00, 6'h07});
		foreach (ROWS[i])
		begin
			xfer(ROWS[i].op, ROWS[i].d, ROWS[i].ack, ROWS[i].rd);
			chk("hs_mode", {15'h0000, hs_mode}, {15'h0000, ROWS[i].hs});
		end
		chk("wr_data", wr_data, 16'h0234);
		chk("int_sel", {15'h0000, int_sel}, 16'h0001);
		chk("gc_pulses", gc_cnt[15:0], 16'h0000);
		// Pointer then a lone upper byte, ended by stop
		xfer(2'h0, 8'h9a, 1'b1, 8'h00);
		xfer(2'h1, 8'h01, 1'b1, 8'h00);
		xfer(2'h1, 8'h06, 1'b1, 8'h00);
		xfer(2'h3, 8'h00, 1'b0, 8'h00);
		chk("wr_be", {14'h0000, wr_be}, {14'h0000, tws_pkg::BE_MSB});
		chk("wr_msb", {8'h00, wr_data[15:8]}, 16'h0006);
		fault(1'b1);
		chk("alert_seen", {15'h0000, alert_seen}, 16'h0001);
		ara(8'h9b);
		fault(1'b0);
		ara(8'h9a);
		fault(1'b1);
		xfer(2'h0, 8'h9b, 1'b1, 8'h00);
		xfer(2'h2, 8'h01, 1'b0, 8'hc3);
		xfer(2'h3, 8'h00, 1'b0, 8'h00);
		chk("alert_read", {15'h0000, alert_active}, 16'h0000);
		chk("rd_pulses", rd_cnt[15:0], 16'h0002);
		xfer(2'h0, 8'h19, 1'b0, 8'h00);
		xfer(2'h3, 8'h00, 1'b0, 8'h00);
		fault(1'b1);
		xfer(2'h0, 8'h00, 1'b1, 8'h00);
		xfer(2'h1, 8'h06, 1'b1, 8'h00);
		xfer(2'h3, 8'h00, 1'b0, 8'h00);
		chk("gc_reset", {gc_cnt[7:0], reg_ptr}, 16'h0100);
		chk("gc_clear", {14'h0000, int_sel, alert_active}, 16'h0000);
		fault(1'b1);
		xfer(2'h0, 8'h19, 1'b0, 8'h00);
		xfer(2'h3, 8'h00, 1'b0, 8'h00);
		fault(1'b0);
		// Overfill the command buffer while the link drains it slowly
		base_a = ack_cnt;
		base_s = stb_cnt;
		push(2'h0, 8'h9a);
		push(2'h1, 8'h02);
		repeat (40) push(2'h1, 8'h5a);
		repeat (20000) if (ack_cnt - base_a < 42) @(posedge ref_clk);
		xfer(2'h3, 8'h00, 1'b0, 8'h00);
		chk("saw_full", {15'h0000, saw_full}, 16'h0001);
		chk("acks", 16'(ack_cnt - base_a), 16'h002a);
		chk("words", 16'(stb_cnt - base_s), 16'h0014);
		// Stuck clock on the second link after the slave starts its ack
		u_bus_b.m_sda_oe <= 1'b1;
		repeat (16) @(posedge ref_clk);
		u_bus_b.m_scl_oe <= 1'b1;
		repeat (8) @(posedge ref_clk);
		for (int i = 7; i >= 0; i--)
			bb(ROWS[0].d[i]);
		u_bus_b.m_sda_oe <= 1'b0;
		repeat (20) @(posedge ref_clk);
		chk("stuck_ack", {15'h0000, u_bus_b.s_sda_oe}, 16'h0001);
		repeat (TO + 40) @(posedge ref_clk);
		chk("stuck_free", {15'h0000, u_bus_b.s_sda_oe}, 16'h0000);
		u_bus_b.m_scl_oe <= 1'b0;
		repeat (8) @(posedge ref_clk);
		// Second reset mid-run must drop the stored pointer and modes again
		rst_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge ref_clk);
		chk("reset_mid", {2'h0, reg_ptr, int_sel, hs_mode, alert_active, cmd_ready, u_bus.scl,
			u_bus.sda}, {2'h0, 8'h00, 6'h07});
		finish_test();
	end
endmodule
